// File: hdl/aesi_pkg.sv
// Purpose: Shared constants for the cipher window link, device end and host end.
// Assumes: One 50 MHz system clock on both ends.
// Notes:   Window byte i (address 0x84 + i) sits at bits [8i+7:8i] of a block.
package aesi_pkg;
   localparam logic [7:0]   ADDR_STATUS  = 8'h82;
   localparam logic [7:0]   ADDR_CTRL    = 8'h83;
   localparam logic [7:0]   ADDR_WIN_LO  = 8'h84;
   localparam logic [7:0]   ADDR_WIN_HI  = 8'h93;
   localparam logic [7:0]   ADDR_MIRROR  = 8'h94;
   localparam int           STAT_ERR_BIT = 7;
   localparam int           STAT_DONE_BIT = 0;
   localparam int           CTRL_REQ_BIT = 7;
   localparam int           CTRL_MODE_LSB = 4;
   localparam int           CTRL_DIR_BIT = 3;
   localparam logic [2:0]   MODE_ECB     = 3'h0;
   localparam logic [2:0]   MODE_KEY     = 3'h1;
   localparam logic [2:0]   MODE_CBC     = 3'h2;
   localparam logic [7:0]   STATUS_RESET = 8'h00;
   localparam logic [7:0]   CTRL_RESET   = 8'h00;
   localparam logic [4:0]   WIN_BYTES    = 5'h10;
   // Timing: the core time is whole 16 MHz periods, then converted to 50 MHz cycles.
   localparam int           SYS_CLK_HZ   = 50_000_000;
   localparam int           CORE_CLK_HZ  = 16_000_000;
   localparam int           T_RUN_NS     = 23400;
   localparam int           T_DONE_MAX_NS = 24000;
   localparam int           CORE_TICKS   = (T_RUN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int           RUN_CYCLES   =
      (CORE_TICKS * (SYS_CLK_HZ / 1_000_000) + (CORE_CLK_HZ / 1_000_000) - 1)
      / (CORE_CLK_HZ / 1_000_000);
   localparam int           DONE_MAX_CYCLES = T_DONE_MAX_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
   // Host command port offsets.
   localparam logic [7:0]   HREG_CMD     = 8'h00;
   localparam logic [7:0]   HREG_CFG     = 8'h01;
   localparam logic [7:0]   HREG_STAT    = 8'h02;
   localparam logic [7:0]   HREG_TX_BASE = 8'h10;
   localparam logic [7:0]   HREG_RX_BASE = 8'h20;
   localparam int           HCMD_RUN_BIT = 0;
   localparam int           HCMD_START_BIT = 1;
   localparam int           HCMD_POLL_BIT = 2;
   localparam int           HCMD_PEEK_BIT = 3;
   localparam logic [4:0]   FAST_LAST    = 5'h11;
endpackage

// File: hdl/aesi_link_if.sv
// Purpose: Byte-level SRAM access link between host and cipher window.
// Assumes: Both ends on clk_sys; the device answers every byte one cycle later.
// Notes:   frm_addr and frm_write are taken with frm_begin.
interface aesi_link_if
(
   input wire logic clk_sys,
   input wire logic reset_n
);
   logic       frm_begin;
   logic       frm_write;
   logic [7:0] frm_addr;
   logic       byte_stb;
   logic [7:0] byte_wdata;
   logic       frm_end;
   logic       rsp_stb;
   logic [7:0] rsp_data;

   modport dev
   (
      input  frm_begin, frm_write, frm_addr, byte_stb, byte_wdata, frm_end,
      output rsp_stb, rsp_data
   );
   modport host
   (
      output frm_begin, frm_write, frm_addr, byte_stb, byte_wdata, frm_end,
      input  rsp_stb, rsp_data
   );
endinterface

// File: hdl/aesi_device.sv
// Purpose: Cipher engine register window reached by SRAM byte accesses.
// Assumes: Host keeps one byte in flight; the round datapath is a stand-in.
// Notes:   Deepest_sleep_state clears every register like reset does.
module aesi_device
   import aesi_pkg::*;
(
   aesi_link_if.dev   link,
   input  wire logic  clk_sys,
   input  wire logic  reset_n,
   input  wire logic  deepest_sleep_state,
   output logic       core_busy,
   output logic       core_done
);
   import aesi_pkg::*;

   typedef struct packed {
      logic         running;
      logic [10:0]  run_cnt;
      logic [2:0]   run_mode;
      logic         run_dir;
      logic [2:0]   mode;
      logic         dir;
      logic         done;
      logic         err;
      logic [127:0] key;
      logic [127:0] round_key;
      logic [127:0] data;
      logic [127:0] chain;
      logic [7:0]   addr;
      logic         wr;
      logic [7:0]   prev_old;
      logic [4:0]   rd_cnt;
      logic         win_rd;
      logic         rsp_stb;
      logic [7:0]   rsp_data;
   } aesi_dev_state_t;

   aesi_dev_state_t state_reg;
   aesi_dev_state_t state_next;

   localparam logic [10:0] RUN_LOAD = 11'(RUN_CYCLES - 1);

   function automatic logic in_window(input logic [7:0] a);
      in_window = (a >= ADDR_WIN_LO) && (a <= ADDR_WIN_HI);
   endfunction

   function automatic logic is_ctrl(input logic [7:0] a);
      is_ctrl = (a == ADDR_CTRL) || (a == ADDR_MIRROR);
   endfunction

   function automatic logic [3:0] win_idx(input logic [7:0] a);
      win_idx = 4'(a - ADDR_WIN_LO);
   endfunction

   // Stand-in for the round datapath: self-inverse, so both directions agree.
   function automatic logic [127:0] cipher_fn(input logic [127:0] din,
                                              input logic [127:0] k);
      cipher_fn = din ^ k;
   endfunction

   function automatic logic [127:0] last_round_key(input logic [127:0] k);
      last_round_key = {k[119:0], k[127:120]};
   endfunction

   function automatic logic [7:0] read_byte(input aesi_dev_state_t s,
                                            input logic [7:0] a);
      logic [3:0] i;
      i = win_idx(a);
      read_byte = 8'h00;
      if (a == ADDR_STATUS)
      begin
         read_byte[STAT_ERR_BIT]  = s.err;
         read_byte[STAT_DONE_BIT] = s.done;
      end
      else if (is_ctrl(a))
      begin
         read_byte[CTRL_MODE_LSB +: 3] = s.mode;
         read_byte[CTRL_DIR_BIT]       = s.dir;
      end
      else if (in_window(a))
      begin
         if (s.mode == MODE_KEY)
         begin
            read_byte = s.round_key[i*8 +: 8];
         end
         else
         begin
            read_byte = s.data[i*8 +: 8];
         end
      end
   endfunction

   always_comb
   begin
      logic [7:0] a;
      logic [7:0] wd;
      logic [2:0] wmode;
      a  = state_reg.addr;
      wd = link.byte_wdata;
      wmode = wd[CTRL_MODE_LSB +: 3];
      state_next = state_reg;
      state_next.rsp_stb = 1'b0;

      if (state_reg.running)
      begin
         if (state_reg.run_cnt == 11'h000)
         begin
            state_next.running   = 1'b0;
            state_next.done      = 1'b1;
            state_next.round_key = last_round_key(state_reg.key);
            if (state_reg.run_mode != MODE_KEY)
            begin
               state_next.data  = cipher_fn(state_reg.data, state_reg.key);
               state_next.chain = cipher_fn(state_reg.data, state_reg.key);
            end
         end
         else
         begin
            state_next.run_cnt = state_reg.run_cnt - 11'h001;
         end
      end

      // Every access arrives over the SRAM link; there is no other path.
      if (link.frm_begin)
      begin
         state_next.addr     = link.frm_addr;
         state_next.wr       = link.frm_write;
         state_next.prev_old = 8'h00;
         state_next.rd_cnt   = 5'h00;
         state_next.win_rd   = 1'b0;
      end
      else if (link.frm_end)
      begin
         if (!state_reg.wr && state_reg.win_rd && (state_reg.rd_cnt < WIN_BYTES))
         begin
            state_next.err = 1'b1;
         end
      end
      else if (link.byte_stb)
      begin
         state_next.addr    = a + 8'h01;
         state_next.rsp_stb = 1'b1;
         if (is_ctrl(a) && state_reg.running)
         begin
            // Any touch of control mid-run aborts and flags it; the byte is dropped.
            state_next.running = 1'b0;
            state_next.err     = 1'b1;
         end
         if (state_reg.wr)
         begin
            if ((a >= ADDR_STATUS) && (a <= ADDR_MIRROR))
            begin
               state_next.rsp_data = state_reg.prev_old;
               state_next.prev_old = read_byte(state_reg, a);
            end
            else
            begin
               state_next.rsp_data = 8'h00;
            end
            if (in_window(a))
            begin
               if (state_reg.mode == MODE_KEY)
               begin
                  state_next.key[win_idx(a)*8 +: 8] = wd;
               end
               else
               begin
                  state_next.data[win_idx(a)*8 +: 8] = wd;
               end
            end
            else if (is_ctrl(a) && !state_reg.running)
            begin
               state_next.mode = wmode;
               state_next.dir  = wd[CTRL_DIR_BIT];
               if (wd[CTRL_REQ_BIT])
               begin
                  state_next.done = 1'b0;
                  if ((wmode > MODE_CBC) || (wd[CTRL_DIR_BIT] && (wmode == MODE_CBC)))
                  begin
                     state_next.err = 1'b1;
                  end
                  else
                  begin
                     state_next.err      = 1'b0;
                     state_next.running  = 1'b1;
                     state_next.run_cnt  = RUN_LOAD;
                     state_next.run_mode = wmode;
                     state_next.run_dir  = wd[CTRL_DIR_BIT];
                     if (wmode == MODE_CBC)
                     begin
                        state_next.data = state_reg.data ^ state_reg.chain;
                     end
                  end
               end
            end
         end
         else
         begin
            state_next.rsp_data = read_byte(state_reg, a);
            if (in_window(a) && (state_reg.mode != MODE_KEY))
            begin
               state_next.win_rd = 1'b1;
               if (state_reg.rd_cnt != WIN_BYTES)
               begin
                  state_next.rd_cnt = state_reg.rd_cnt + 5'h01;
               end
            end
         end
      end

      if (deepest_sleep_state)
      begin
         state_next = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign link.rsp_stb  = state_reg.rsp_stb;
   assign link.rsp_data = state_reg.rsp_data;
   assign core_busy     = state_reg.running;
   assign core_done     = state_reg.done;
endmodule

// File: hdl/aesi_host.sv
// Purpose: Host end that drives fast window accesses and status polls.
// Assumes: Software uses the plain register port; one command at a time.
// Notes:   A run command without start bit is the dummy access that fetches results.
module aesi_host
   import aesi_pkg::*;
(
   aesi_link_if.host  link,
   input  wire logic  clk_sys,
   input  wire logic  reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic  reg_wr,
   input  wire logic  reg_rd,
   output logic [7:0] reg_rdata
);
   import aesi_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_BEGIN, ST_SEND, ST_WAIT, ST_END} aesi_hst_t;

   typedef struct packed {
      aesi_hst_t        st;
      logic             poll;
      logic             peek;
      logic             start;
      logic [4:0]       idx;
      logic [7:0]       cfg;
      logic [7:0]       status;
      logic [15:0][7:0] tx;
      logic [15:0][7:0] rx;
      logic             frm_begin;
      logic             frm_write;
      logic [7:0]       frm_addr;
      logic             byte_stb;
      logic [7:0]       byte_wdata;
      logic             frm_end;
      logic [7:0]       rdata;
   } aesi_host_state_t;

   aesi_host_state_t s_reg;
   aesi_host_state_t s_next;

   function automatic logic [7:0] fast_byte(input aesi_host_state_t s);
      if (s.idx == 5'h00)
      begin
         fast_byte = s.cfg & 8'h7F;
      end
      else if (s.idx == FAST_LAST)
      begin
         fast_byte = (s.cfg & 8'h7F) | {s.start, 7'h00};
      end
      else
      begin
         fast_byte = s.tx[4'(s.idx - 5'h01)];
      end
   endfunction

   always_comb
   begin
      s_next = s_reg;
      s_next.frm_begin = 1'b0;
      s_next.byte_stb  = 1'b0;
      s_next.frm_end   = 1'b0;
      s_next.rdata     = 8'h00;
      if (reg_rd)
      begin
         if (reg_addr == HREG_CFG)
         begin
            s_next.rdata = s_reg.cfg;
         end
         else if (reg_addr == HREG_STAT)
         begin
            s_next.rdata = s_reg.status;
         end
         else if (reg_addr == HREG_CMD)
         begin
            s_next.rdata = {7'h00, s_reg.st != ST_IDLE};
         end
         else if ((reg_addr & 8'hF0) == HREG_TX_BASE)
         begin
            s_next.rdata = s_reg.tx[reg_addr[3:0]];
         end
         else if ((reg_addr & 8'hF0) == HREG_RX_BASE)
         begin
            s_next.rdata = s_reg.rx[reg_addr[3:0]];
         end
      end
      if (reg_wr)
      begin
         if (reg_addr == HREG_CFG)
         begin
            s_next.cfg = reg_wdata;
         end
         else if ((reg_addr & 8'hF0) == HREG_TX_BASE)
         begin
            s_next.tx[reg_addr[3:0]] = reg_wdata;
         end
         else if ((reg_addr == HREG_CMD) && (s_reg.st == ST_IDLE))
         begin
            // A poll reads status, or one window byte with peek, never control, so a run survives it.
            if (reg_wdata[HCMD_POLL_BIT] || reg_wdata[HCMD_RUN_BIT])
            begin
               s_next.st    = ST_BEGIN;
               s_next.poll  = reg_wdata[HCMD_POLL_BIT];
               s_next.peek  = reg_wdata[HCMD_PEEK_BIT];
               s_next.start = reg_wdata[HCMD_START_BIT];
               s_next.idx   = 5'h00;
            end
         end
      end
      case (s_reg.st)
         ST_BEGIN:
         begin
            s_next.frm_begin = 1'b1;
            s_next.frm_write = !s_reg.poll;
            s_next.frm_addr  = s_reg.poll ? ADDR_STATUS : ADDR_CTRL;
            if (s_reg.poll && s_reg.peek)
            begin
               // A one-byte window read; it is short on purpose, so the device flags it unless the mode is key.
               s_next.frm_addr = ADDR_WIN_LO;
            end
            s_next.st        = ST_SEND;
         end
         ST_SEND:
         begin
            s_next.byte_stb   = 1'b1;
            s_next.byte_wdata = s_reg.poll ? 8'h00 : fast_byte(s_reg);
            s_next.st         = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (link.rsp_stb)
            begin
               if (s_reg.poll)
               begin
                  s_next.status = link.rsp_data;
               end
               else if ((s_reg.idx >= 5'h02) && (s_reg.idx <= FAST_LAST))
               begin
                  s_next.rx[4'(s_reg.idx - 5'h02)] = link.rsp_data;
               end
               if (s_reg.poll || (s_reg.idx == FAST_LAST))
               begin
                  s_next.st = ST_END;
               end
               else
               begin
                  s_next.idx = s_reg.idx + 5'h01;
                  s_next.st  = ST_SEND;
               end
            end
         end
         ST_END:
         begin
            s_next.frm_end = 1'b1;
            s_next.st      = ST_IDLE;
         end
         default:
         begin
            s_next.st = s_next.st;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign link.frm_begin  = s_reg.frm_begin;
   assign link.frm_write  = s_reg.frm_write;
   assign link.frm_addr   = s_reg.frm_addr;
   assign link.byte_stb   = s_reg.byte_stb;
   assign link.byte_wdata = s_reg.byte_wdata;
   assign link.frm_end    = s_reg.frm_end;
   assign reg_rdata       = s_reg.rdata;
endmodule

// File: tb/aesi_link_asserts.sv
// Purpose: Timing checks on the link between host end and cipher device.
// Assumes: One clock; reset_n asynchronous, active low.
// Notes:   Follows the auto-incremented link address to spot control bytes.
module aesi_link_asserts
   import aesi_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       frm_begin,
   input wire logic       frm_write,
   input wire logic [7:0] frm_addr,
   input wire logic       byte_stb,
   input wire logic [7:0] byte_wdata,
   input wire logic       frm_end,
   input wire logic       rsp_stb,
   input wire logic [7:0] rsp_data,
   input wire logic       core_busy,
   input wire logic       core_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  addr_reg;
   logic        first_reg;
   logic [11:0] run_reg;
   logic        ctrl_hit;
   logic        legal;
   logic        start_ok;
   logic        start_bad;

   assign ctrl_hit  = byte_stb && (addr_reg == ADDR_CTRL || addr_reg == ADDR_MIRROR);
   assign legal     = byte_wdata[CTRL_MODE_LSB +: 3] == MODE_ECB
                      || byte_wdata[CTRL_MODE_LSB +: 3] == MODE_KEY
                      || (byte_wdata[CTRL_MODE_LSB +: 3] == MODE_CBC
                          && !byte_wdata[CTRL_DIR_BIT]);
   assign start_ok  = ctrl_hit && frm_write && byte_wdata[CTRL_REQ_BIT] && !core_busy && legal;
   assign start_bad = ctrl_hit && frm_write && byte_wdata[CTRL_REQ_BIT] && !core_busy && !legal;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         addr_reg  <= 8'h00;
         first_reg <= 1'b0;
         run_reg   <= 12'h000;
      end
      else
      begin
         addr_reg  <= frm_begin ? frm_addr : (byte_stb ? addr_reg + 8'h01 : addr_reg);
         first_reg <= frm_begin ? frm_write : (byte_stb ? 1'b0 : first_reg);
         run_reg   <= core_busy ? run_reg + 12'h001 : 12'h000;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   rsp_after_byte_a:
   assert property (byte_stb |=> rsp_stb) else $error("byte left unanswered");
   rsp_has_cause_a:
   assert property (rsp_stb |-> $past(byte_stb)) else $error("answer without a byte");
   first_zero_a:
   assert property (byte_stb && first_reg |=> rsp_data == 8'h00)
      else $error("first write byte not answered with zero");
   run_bound_a:
   assert property (run_reg <= DONE_MAX_CYCLES) else $error("run lasts too long");
   busy_not_done_a:
   assert property (core_busy |-> !core_done) else $error("done while busy");
   done_ends_run_a:
   assert property ($rose(core_done) |-> $past(core_busy) && !core_busy)
      else $error("done rose outside a run end");
   start_runs_a:
   assert property (start_ok |-> ##[1:2] (core_busy && !core_done))
      else $error("start byte did not launch a run");
   bad_mode_a:
   assert property (start_bad |=> !core_busy [*3]) else $error("reserved mode ran");
   ctrl_abort_a:
   assert property (ctrl_hit && core_busy |-> ##[1:2] !core_busy)
      else $error("control access did not abort");

   cover property (start_ok);
   cover property (ctrl_hit && core_busy);
   cover property ($rose(core_done));
endmodule

// File: tb/tb_top.sv
// Purpose: Runs host and device against each other through the register port.
// Assumes: Stand-in cipher, result is data XOR key, round key rotates by 8.
// Notes:   Deepest_sleep_state is driven directly at the device.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aesi_pkg::*;

   localparam logic [127:0] KEY = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
   localparam logic [127:0] PTX = 128'h00112233445566778899AABBCCDDEEFF;
   localparam logic [127:0] QTX = 128'hA5A55A5A0123456789ABCDEFFEDCBA98;

   logic       clk_sys = 1'b0;
   logic       reset_n = 1'b0;
   logic       deepest_sleep_state = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       core_busy;
   logic       core_done;
   int         fail_count = 0;
   int         num_checks = 0;
   int         cycles = 0;

   always #10 clk_sys = ~clk_sys;

   aesi_link_if aesi_link_if_inst (.clk_sys(clk_sys), .reset_n(reset_n));
   aesi_device aesi_device_inst (.link(aesi_link_if_inst.dev), .clk_sys(clk_sys),
      .reset_n(reset_n), .deepest_sleep_state(deepest_sleep_state),
      .core_busy(core_busy), .core_done(core_done));
   aesi_host aesi_host_inst (.link(aesi_link_if_inst.host), .clk_sys(clk_sys),
      .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   aesi_link_asserts aesi_link_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .frm_begin(aesi_link_if_inst.frm_begin), .frm_write(aesi_link_if_inst.frm_write),
      .frm_addr(aesi_link_if_inst.frm_addr), .byte_stb(aesi_link_if_inst.byte_stb),
      .byte_wdata(aesi_link_if_inst.byte_wdata), .frm_end(aesi_link_if_inst.frm_end),
      .rsp_stb(aesi_link_if_inst.rsp_stb), .rsp_data(aesi_link_if_inst.rsp_data),
      .core_busy(core_busy), .core_done(core_done));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Six whole runs plus traffic stay far below this ceiling.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fail_count++;
         $display("unexpected at %0t: run hung", $time);
         give_verdict();
      end
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp, input string what);
      check8({7'h00, got}, {7'h00, exp}, what);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_idle();
      logic [7:0] s;
      for (int i = 0; i < 80; i++)
      begin
         rd(HREG_CMD, s);
         if (s[HCMD_RUN_BIT] === 1'b0)
            return;
      end
      check1(1'b1, 1'b0, "host stuck");
   endtask

   task automatic fast(input logic [7:0] cfg, input logic [7:0] cmd);
      wr(HREG_CFG, cfg);
      wr(HREG_CMD, cmd);
      wait_idle();
   endtask

   task automatic load_tx(input logic [127:0] blk);
      for (int i = 0; i < 16; i++)
         wr(HREG_TX_BASE + 8'(i), blk[8*i+:8]);
   endtask

   task automatic check_rx(input logic [127:0] exp, input string what);
      logic [7:0] b;
      for (int i = 0; i < 16; i++)
      begin
         rd(HREG_RX_BASE + 8'(i), b);
         check8(b, exp[8*i+:8], what);
      end
   endtask

   task automatic check_status(input logic [7:0] exp);
      logic [7:0] s;
      wr(HREG_CMD, 8'h04);
      wait_idle();
      rd(HREG_STAT, s);
      check8(s, exp, "status byte");
   endtask

   task automatic wait_done();
      // Sampled just after the edge, so a done set by that edge is seen.
      for (int n = 0; n < DONE_MAX_CYCLES && core_done !== 1'b1; n++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check1(core_done, 1'b1, "done flag");
   endtask

   task automatic t_reset();
      logic [7:0] v;
      rd(8'h7F, v);
      check8(v, 8'h00, "unmapped read");
      check_status(STATUS_RESET);
      $display("reset test finished");
   endtask

   task automatic t_ecb();
      load_tx(KEY);
      fast(8'h10, 8'h03);
      wait_done();
      check_status(8'h01);
      load_tx(PTX);
      fast(8'h00, 8'h03);
      check_rx(128'h0, "data page kept apart from key");
      wait_done();
      load_tx(128'h0);
      fast(8'h00, 8'h01);
      check_rx(PTX ^ KEY, "ecb result");
      wr(HREG_CMD, 8'h0C);
      wait_idle();
      check_status(8'h81);
      $display("ecb test finished");
   endtask

   task automatic t_keyread();
      load_tx(KEY);
      fast(8'h10, 8'h01);
      check_rx({KEY[119:0], KEY[127:120]}, "round key");
      $display("key read test finished");
   endtask

   task automatic t_cbc();
      load_tx(QTX);
      fast(8'h20, 8'h03);
      wait_done();
      load_tx(128'h0);
      fast(8'h20, 8'h01);
      check_rx(QTX ^ PTX, "cbc result");
      $display("cbc test finished");
   endtask

   task automatic t_badmode();
      logic [7:0] bad [3] = '{8'h30, 8'h28, 8'h70};
      for (int i = 0; i < 3; i++)
      begin
         fast(bad[i], 8'h03);
         check1(core_busy, 1'b0, "reserved mode ran");
         check_status(8'h80);
         fast(8'h08, 8'h03);
         wait_done();
         check_status(8'h01);
      end
      $display("bad mode test finished");
   endtask

   task automatic t_abort();
      load_tx(PTX);
      fast(8'h00, 8'h03);
      check1(core_busy, 1'b1, "run started");
      check_status(8'h00);
      check1(core_busy, 1'b1, "poll kept run");
      fast(8'h00, 8'h01);
      check1(core_busy, 1'b0, "run aborted");
      check_status(8'h80);
      $display("abort test finished");
   endtask

   task automatic t_sleep();
      @(posedge clk_sys);
      deepest_sleep_state <= 1'b1;
      @(posedge clk_sys);
      deepest_sleep_state <= 1'b0;
      check_status(STATUS_RESET);
      load_tx(128'h0);
      fast(8'h00, 8'h01);
      check_rx(128'h0, "window after sleep");
      $display("sleep test finished");
   endtask

   initial
   begin
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset();
      t_ecb();
      t_keyread();
      t_cbc();
      t_badmode();
      t_abort();
      t_sleep();
      give_verdict();
   end
endmodule
